// File: prh_handshake.sv
`timescale 1ns/1ps
// Functional notes
// - link completion pin held low during link configuration, released when finished.
// - transceivers held in reset while fundamental reset pin low.
// - fundamental reset acts only with PCIe hard block; otherwise pin is user input.
// - request honoured only in external-host sixteen-bit fast parallel load.
// - ready pin pulled low until device can begin, then released.
// - fault pin pulled low during partial reload while no error seen.
// - fault pin released when an error is detected during reload.
// - completion pin pulled low until partial reload finished, then released.
module prh_handshake
    import prh_pkg::*;
(
    // clock and reset
    input  wire logic sys_clk_i,
    input  wire logic rstn_i,
    // configuration engine status
    input  wire logic full_config_complete_i,
    input  wire logic link_cfg_start_i,
    input  wire logic link_cfg_finished_i,
    input  wire logic ext_host_x16_mode_i,
    input  wire logic pr_engine_ready_i,
    input  wire logic pr_fault_detect_i,
    input  wire logic pr_load_finished_i,
    // transceiver reset pin and use strap
    input  wire logic transceiver_fund_reset_n_i,
    input  wire logic pcie_hard_block_used_i,
    // partial reload request pin
    input  wire logic partial_reload_request_i,
    // open-drain status pins
    output prh_od_s   link_config_complete_o,
    output prh_od_s   partial_reload_ready_o,
    output prh_od_s   partial_reload_fault_o,
    output prh_od_s   partial_reload_complete_o,
    // transceiver reset and user input
    output logic      xcvr_reset_o,
    output logic      user_io_o,
    // engine view of handshake
    output logic      full_config_seen_o,
    output prh_state_e pr_state_o
);

    // ------------------------------------------------------------------
    // declarations
    // ------------------------------------------------------------------
    prh_state_e state_q;
    prh_state_e state_d;
    logic       link_done_q;
    logic       req_honoured;

    // ------------------------------------------------------------------
    // link configuration completion
    // ------------------------------------------------------------------
    // finish wins over a start in the same cycle
    always_ff @(posedge sys_clk_i) begin
        if (!rstn_i) begin
            link_done_q <= PRH_LINK_DONE_RST;
        end else if (link_cfg_finished_i) begin
            link_done_q <= 1'b1;
        end else if (link_cfg_start_i) begin
            link_done_q <= 1'b0;
        end
    end

    // only meaningful to the host while full completion is high
    always_ff @(posedge sys_clk_i) begin
        if (!rstn_i) begin
            full_config_seen_o <= 1'b0;
        end else begin
            full_config_seen_o <= full_config_complete_i;
        end
    end

    // ------------------------------------------------------------------
    // transceiver fundamental reset
    // ------------------------------------------------------------------
    always_ff @(posedge sys_clk_i) begin
        if (!rstn_i) begin
            xcvr_reset_o <= PRH_XCVR_RST_RST;
            user_io_o    <= PRH_USER_IO_RST;
        end else begin
            xcvr_reset_o <= pcie_hard_block_used_i
                            & ~transceiver_fund_reset_n_i;
            user_io_o    <= pcie_hard_block_used_i ? 1'b0
                            : transceiver_fund_reset_n_i;
        end
    end

    // ------------------------------------------------------------------
    // partial reload handshake
    // ------------------------------------------------------------------
    assign req_honoured = partial_reload_request_i & ext_host_x16_mode_i;

    always_comb begin
        state_d = state_q;
        if (!req_honoured) begin
            state_d = PRH_IDLE;
        end else begin
            unique case (state_q)
                PRH_IDLE: begin
                    state_d = PRH_PREP;
                end
                PRH_PREP: begin
                    if (pr_engine_ready_i) begin
                        state_d = PRH_LOAD;
                    end
                end
                PRH_LOAD: begin
                    // a fault in the same cycle as the finish still reports
                    if (pr_fault_detect_i) begin
                        state_d = PRH_FAULT;
                    end else if (pr_load_finished_i) begin
                        state_d = PRH_DONE;
                    end
                end
                PRH_DONE: begin
                    state_d = PRH_DONE;
                end
                PRH_FAULT: begin
                    state_d = PRH_FAULT;
                end
                default: begin
                    state_d = PRH_IDLE;
                end
            endcase
        end
    end

    always_ff @(posedge sys_clk_i) begin
        if (!rstn_i) begin
            state_q <= PRH_STATE_RST;
        end else begin
            state_q <= state_d;
        end
    end

    always_ff @(posedge sys_clk_i) begin
        if (!rstn_i) begin
            pr_state_o <= PRH_STATE_RST;
        end else begin
            pr_state_o <= state_q;
        end
    end

    // ------------------------------------------------------------------
    // open-drain pin drivers
    // ------------------------------------------------------------------
    // one flop stage per pin keeps every pin glitch free
    prh_od_drv u_link_done (
        .sys_clk_i (sys_clk_i),
        .rstn_i    (rstn_i),
        .release_i (link_done_q),
        .pin_o     (link_config_complete_o)
    );

    prh_od_drv u_ready (
        .sys_clk_i (sys_clk_i),
        .rstn_i    (rstn_i),
        .release_i ((state_q == PRH_LOAD) || (state_q == PRH_DONE) ||
                    (state_q == PRH_FAULT)),
        .pin_o     (partial_reload_ready_o)
    );

    // held low also when idle, so a released pin always means a fault
    prh_od_drv u_fault (
        .sys_clk_i (sys_clk_i),
        .rstn_i    (rstn_i),
        .release_i (state_q == PRH_FAULT),
        .pin_o     (partial_reload_fault_o)
    );

    prh_od_drv u_complete (
        .sys_clk_i (sys_clk_i),
        .rstn_i    (rstn_i),
        .release_i (state_q == PRH_DONE),
        .pin_o     (partial_reload_complete_o)
    );

    // ------------------------------------------------------------------
    // assertions
    // ------------------------------------------------------------------
    default clocking cb @(posedge sys_clk_i); endclocking
    default disable iff (!rstn_i);

    a_link_hold_low: assert property (
        link_cfg_start_i && !link_cfg_finished_i |-> ##2 link_config_complete_o.oe)
        else $error("link completion not held low after start");

    a_link_release: assert property (
        link_cfg_finished_i |-> ##2 !link_config_complete_o.oe)
        else $error("link completion not released after finish");

    a_xcvr_in_reset: assert property (
        pcie_hard_block_used_i && !transceiver_fund_reset_n_i |=> xcvr_reset_o)
        else $error("transceivers not held in reset");

    a_xcvr_user_io: assert property (
        !pcie_hard_block_used_i |=>
            !xcvr_reset_o && (user_io_o == $past(transceiver_fund_reset_n_i)))
        else $error("reset pin not acting as user input");

    a_request_gated: assert property (
        !ext_host_x16_mode_i |=> state_q == PRH_IDLE)
        else $error("request honoured outside fast parallel mode");

    a_ready_low: assert property (
        (state_q == PRH_IDLE) || (state_q == PRH_PREP) |=> partial_reload_ready_o.oe)
        else $error("ready released before device able");

    a_fault_low: assert property (
        state_q == PRH_LOAD |=> partial_reload_fault_o.oe)
        else $error("fault pin released without error");

    a_fault_release: assert property (
        state_q == PRH_LOAD && pr_fault_detect_i && req_honoured
            |-> ##2 !partial_reload_fault_o.oe [*2])
        else $error("fault pin not released on error");

    a_done_release: assert property (
        state_q == PRH_LOAD && pr_load_finished_i && !pr_fault_detect_i && req_honoured
            |-> ##2 !partial_reload_complete_o.oe)
        else $error("completion pin not released on finish");

endmodule : prh_handshake

// File: prh_pkg.sv
package prh_pkg;

    // ------------------------------------------------------------------
    // partial reload handshake states, gray along idle-prep-load-done
    // ------------------------------------------------------------------
    typedef enum logic [2:0] {
        PRH_IDLE  = 3'h0,
        PRH_PREP  = 3'h1,
        PRH_LOAD  = 3'h3,
        PRH_DONE  = 3'h2,
        PRH_FAULT = 3'h6
    } prh_state_e;

    // ------------------------------------------------------------------
    // open-drain pin carrier
    // ------------------------------------------------------------------
    typedef struct packed {
        logic o;
        logic oe;
    } prh_od_s;

    // ------------------------------------------------------------------
    // reset values
    // ------------------------------------------------------------------
    localparam prh_state_e PRH_STATE_RST   = PRH_IDLE;
    localparam logic       PRH_OD_OE_RST   = 1'b1;
    localparam logic       PRH_OD_LEVEL    = 1'b0;
    localparam logic       PRH_LINK_DONE_RST = 1'b0;
    localparam logic       PRH_XCVR_RST_RST  = 1'b1;
    localparam logic       PRH_USER_IO_RST   = 1'b0;

endpackage : prh_pkg

// File: prh_od_drv.sv
`timescale 1ns/1ps
module prh_od_drv
    import prh_pkg::*;
(
    // clock and reset
    input  wire logic    sys_clk_i,
    input  wire logic    rstn_i,
    // control
    input  wire logic    release_i,
    // pin
    output prh_od_s      pin_o
);

    // ------------------------------------------------------------------
    // pin register
    // ------------------------------------------------------------------
    // pin pulls low from reset so the host never sees a false high
    always_ff @(posedge sys_clk_i) begin
        if (!rstn_i) begin
            pin_o.o  <= PRH_OD_LEVEL;
            pin_o.oe <= PRH_OD_OE_RST;
        end else begin
            pin_o.o  <= PRH_OD_LEVEL;
            pin_o.oe <= ~release_i;
        end
    end

endmodule : prh_od_drv

// File: prh_host_model.sv
`timescale 1ns/1ps
module prh_host_model
    import prh_pkg::*;
(
    // clock
    input  wire logic sys_clk_i,
    // bench intent
    input  wire logic want_i,
    // pin levels seen by host
    input  wire logic full_cfg_i,
    input  wire logic link_level_i,
    input  wire logic ready_level_i,
    // host outputs
    output logic      request_o,
    output logic      link_ok_o,
    output logic      ready_seen_o
);
    // ------------------------------------------------------------------
    // request and status view
    // ------------------------------------------------------------------
    assign request_o    = want_i;
    // link pin is noise until full configuration completes
    assign link_ok_o    = full_cfg_i ? link_level_i : 1'b0;
    // data may only follow once ready is seen under request, sampled on the clock
    always_ff @(posedge sys_clk_i) begin
        ready_seen_o <= request_o & ready_level_i;
    end
endmodule : prh_host_model

// File: test_partial_reconfig_handshake.sv
`timescale 1ns/1ps
module test_partial_reconfig_handshake
    import prh_pkg::*;
;
    logic       sys_clk_i = 1'b0;
    logic       rstn_i    = 1'b0;
    logic       full_cfg, link_start, link_fin, mode, eng_rdy, fault, ld_fin;
    logic       fund_n, pcie_used, want, request, link_ok, host_rdy;
    logic       xcvr_rst, user_io, cfg_seen;
    prh_od_s    link_pin, rdy_pin, flt_pin, cmp_pin;
    prh_state_e st;
    logic [5:0] q[$];
    logic [5:0] cur, prev, v;
    int         errors = 0;
    int         total_checks = 0;

    assign v = {link_pin.oe, rdy_pin.oe, flt_pin.oe, cmp_pin.oe, xcvr_rst, user_io};
    always #5 sys_clk_i = ~sys_clk_i;

    prh_handshake prh_handshake_i (.sys_clk_i(sys_clk_i), .rstn_i(rstn_i),
        .full_config_complete_i(full_cfg), .link_cfg_start_i(link_start),
        .link_cfg_finished_i(link_fin), .ext_host_x16_mode_i(mode),
        .pr_engine_ready_i(eng_rdy), .pr_fault_detect_i(fault),
        .pr_load_finished_i(ld_fin), .transceiver_fund_reset_n_i(fund_n),
        .pcie_hard_block_used_i(pcie_used), .partial_reload_request_i(request),
        .link_config_complete_o(link_pin), .partial_reload_ready_o(rdy_pin),
        .partial_reload_fault_o(flt_pin), .partial_reload_complete_o(cmp_pin),
        .xcvr_reset_o(xcvr_rst), .user_io_o(user_io),
        .full_config_seen_o(cfg_seen), .pr_state_o(st));

    // pull-ups: a released pin reads high
    prh_host_model prh_host_model_i (.sys_clk_i(sys_clk_i), .want_i(want),
        .full_cfg_i(full_cfg), .link_level_i(link_pin.oe ? link_pin.o : 1'b1),
        .ready_level_i(rdy_pin.oe ? rdy_pin.o : 1'b1), .request_o(request),
        .link_ok_o(link_ok), .ready_seen_o(host_rdy));

    // ------------------------------------------------------------------
    // helpers
    // ------------------------------------------------------------------
    task automatic check(input logic [5:0] seen, input logic [5:0] exp);
        total_checks++;
        if (seen !== exp) begin
            errors++;
            $display("Error %0t: saw %b expected %b", $time, seen, exp);
        end
    endtask : check

    task automatic final_report();
        $display("checks %0d errors %0d", total_checks, errors);
        if (errors == 0 && total_checks > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask : final_report

    task automatic expect_v(input logic [5:0] nv);
        q.push_back(nv);
        cur = nv;
    endtask : expect_v

    // bounded wait for queued pin changes, then a quiet gap
    task automatic settle();
        int n;
        n = 0;
        while (q.size() != 0 && n < 10) begin
            @(negedge sys_clk_i);
            n++;
        end
        if (q.size() != 0) begin
            errors++;
            $display("Error %0t: pin change timeout", $time);
            final_report();
        end
        repeat (3) @(negedge sys_clk_i);
    endtask : settle

    // ------------------------------------------------------------------
    // monitor: any pin change consumes the oldest note
    // ------------------------------------------------------------------
    always @(negedge sys_clk_i) begin
        if (!rstn_i) begin
            prev = 6'h3E;
        end else if (v !== prev) begin
            if (q.size() == 0) check(v, prev);
            else check(v, q.pop_front());
            prev = v;
        end
    end

    // ------------------------------------------------------------------
    // stimulus
    // ------------------------------------------------------------------
    initial begin
        logic [1:0] r;
        {full_cfg, link_start, link_fin, mode, eng_rdy, fault, ld_fin, fund_n, want} = '0;
        pcie_used = 1'b1;
        cur = 6'h3E;
        void'($urandom(18832));
        repeat (12) @(negedge sys_clk_i);
        rstn_i = 1'b1;
        for (int i = 0; i < 10; i++) begin
            r = (i < 4) ? i[1:0] : 2'($urandom);
            if ({cur[5:2], r[0] & ~r[1], ~r[0] & r[1]} !== cur)
                expect_v({cur[5:2], r[0] & ~r[1], ~r[0] & r[1]});
            pcie_used = r[0];
            fund_n = r[1];
            settle();
        end
        expect_v({1'b0, cur[4:0]});
        link_fin = 1'b1;
        @(negedge sys_clk_i);
        link_fin = 1'b0;
        settle();
        check({4'h0, cfg_seen, link_ok}, 6'h00);
        full_cfg = 1'b1;
        @(negedge sys_clk_i);
        check({4'h0, cfg_seen, link_ok}, 6'h03);
        // simultaneous start and finish must leave the pin released
        {link_start, link_fin} = 2'b11;
        @(negedge sys_clk_i);
        {link_start, link_fin} = 2'b00;
        settle();
        expect_v({1'b1, cur[4:0]});
        link_start = 1'b1;
        @(negedge sys_clk_i);
        link_start = 1'b0;
        settle();
        want = 1'b1;
        settle();
        check({3'h0, st}, {3'h0, PRH_IDLE});
        mode = 1'b1;
        settle();
        check({3'h0, st}, {3'h0, PRH_PREP});
        check({5'h00, host_rdy}, 6'h00);
        expect_v({cur[5], 1'b0, cur[3:0]});
        eng_rdy = 1'b1;
        settle();
        check({5'h00, host_rdy}, 6'h01);
        expect_v({cur[5:3], 1'b0, cur[1:0]});
        ld_fin = 1'b1;
        @(negedge sys_clk_i);
        ld_fin = 1'b0;
        settle();
        expect_v({cur[5], 1'b1, cur[3], 1'b1, cur[1:0]});
        want = 1'b0;
        settle();
        expect_v({cur[5], 1'b0, cur[3:0]});
        want = 1'b1;
        settle();
        // fault beats finish in the same cycle
        expect_v({cur[5:4], 1'b0, cur[2:0]});
        {fault, ld_fin} = 2'b11;
        @(negedge sys_clk_i);
        {fault, ld_fin} = 2'b00;
        settle();
        expect_v({cur[5], 2'b11, cur[2:0]});
        mode = 1'b0;
        settle();
        check({2'h0, link_pin.o, rdy_pin.o, flt_pin.o, cmp_pin.o}, 6'h00);
        final_report();
    end
endmodule : test_partial_reconfig_handshake
